// ### hw/rtc_hour_alarm.sv
/*
  Hour counter, interval alarm, crystal trim registers, calibration output and pin setup.
  Assumes an 8-bit SFR port from the core, a minute-wrap pulse from the minute counter and
  tick pulses on the 200 MHz clock; rst is the supply-up reset only.
*/
`default_nettype none

module rtc_hour_alarm
#(
  parameter int HOUR_WIDTH = 8
)
(
  input  wire logic                           clock,
  input  wire logic                           rst,
  input  wire logic                           clk_en,
  input  wire rtc_hour_alarm_pkg::sfr_req_t   sfr_req,
  output logic [7:0]                          sfr_rdata,
  input  wire logic                           minute_wrap,
  input  wire logic                           tick_128th,
  input  wire logic                           tick_second,
  input  wire logic                           tick_minute,
  input  wire logic                           ext_irq0_pin,
  input  wire logic                           ext_irq1_pin,
  output logic                                clock_irq_pending,
  output logic                                cal_pin_out,
  output logic                                cal_pin_oe,
  output logic signed [8:0]                   trim_total,
  output rtc_hour_alarm_pkg::pin_func_t        pin_func,
  output logic                                ext_irq0_req,
  output logic                                ext_irq1_req,
  output logic                                battery_ctrl_input
);

  // Only an eight-bit hour register is served by the decode below, so refuse others early.
  if (HOUR_WIDTH != 8)
  begin : g_width_check
    $error("HOUR_WIDTH must be 8");
  end

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  logic [7:0] hr_counter_q;
  logic [7:0] alarm_interval_q;
  logic [7:0] nominal_crystal_trim_q;
  logic [7:0] thermal_crystal_trim_q;
  logic [7:0] pin_function_config_q;
  logic [7:0] clock_config_q;
  logic [7:0] write_unlock_key_q;
  logic [7:0] interval_count_q;
  logic       held_q;

  // ----------------------------------------------------------------
  // Address decode
  // ----------------------------------------------------------------
  logic wr_hour_w;
  logic wr_alarm_w;
  logic wr_nom_w;
  logic wr_therm_w;
  logic wr_pin_w;
  logic wr_cfg_w;
  logic wr_key_w;
  logic unlocked_w;

  assign unlocked_w = (write_unlock_key_q == rtc_hour_alarm_pkg::UNLOCK_VALUE);
  assign wr_hour_w  = sfr_req.wr && unlocked_w &&
                      (sfr_req.addr == rtc_hour_alarm_pkg::ADDR_HR_COUNTER);
  assign wr_pin_w   = sfr_req.wr && unlocked_w &&
                      (sfr_req.addr == rtc_hour_alarm_pkg::ADDR_PIN_FUNC);
  assign wr_alarm_w = sfr_req.wr && (sfr_req.addr == rtc_hour_alarm_pkg::ADDR_ALARM_INT);
  assign wr_nom_w   = sfr_req.wr && (sfr_req.addr == rtc_hour_alarm_pkg::ADDR_NOM_TRIM);
  assign wr_therm_w = sfr_req.wr && (sfr_req.addr == rtc_hour_alarm_pkg::ADDR_THERM_TRIM);
  assign wr_cfg_w   = sfr_req.wr && (sfr_req.addr == rtc_hour_alarm_pkg::ADDR_CLOCK_CFG);
  assign wr_key_w   = sfr_req.wr && (sfr_req.addr == rtc_hour_alarm_pkg::ADDR_UNLOCK_KEY);

  // ----------------------------------------------------------------
  // Hour counting
  // ----------------------------------------------------------------
  logic       day_mode_w;
  logic [7:0] hour_last_w;
  logic       hour_wrap_w;
  logic [7:0] hr_counter_d;

  assign day_mode_w  = clock_config_q[rtc_hour_alarm_pkg::CC_DAY_LEN];
  assign hour_last_w = day_mode_w ? rtc_hour_alarm_pkg::HOUR_LAST_24
                                  : rtc_hour_alarm_pkg::HOUR_LAST_256;
  assign hour_wrap_w = minute_wrap && (hr_counter_q >= hour_last_w);
  assign hr_counter_d = wr_hour_w   ? sfr_req.wdata :
                        hour_wrap_w ? rtc_hour_alarm_pkg::REG_RESET :
                        minute_wrap ? hr_counter_q + 8'h01 : hr_counter_q;

  // ----------------------------------------------------------------
  // Interval alarm
  // ----------------------------------------------------------------
  logic iten_w;
  logic single_w;
  logic base_tick_w;
  logic match_w;
  logic [1:0] its_w;

  assign iten_w   = clock_config_q[rtc_hour_alarm_pkg::CC_ITEN];
  assign single_w = clock_config_q[rtc_hour_alarm_pkg::CC_SINGLE];
  assign its_w    = clock_config_q[rtc_hour_alarm_pkg::CC_ITS_HI:rtc_hour_alarm_pkg::CC_ITS_LO];
  assign base_tick_w = (its_w == rtc_hour_alarm_pkg::BASE_128TH)  ? tick_128th  :
                       (its_w == rtc_hour_alarm_pkg::BASE_SECOND) ? tick_second :
                       (its_w == rtc_hour_alarm_pkg::BASE_MINUTE) ? tick_minute : minute_wrap;
  // eight-bit compare
  // A zero interval never matches; without the guard the count would wrap to it after 256 ticks.
  assign match_w = iten_w && !held_q && base_tick_w && (alarm_interval_q != 8'h00) &&
                   ((interval_count_q + 8'h01) == alarm_interval_q);

  // Counter clears on disable; single-shot mode holds it after the alarm.
  always_ff @(posedge clock or posedge rst)
  begin
    if (rst)
    begin
      interval_count_q <= 8'h00;
      held_q           <= 1'b0;
    end
    else if (clk_en)
    begin
      if (!iten_w)
      begin
        interval_count_q <= 8'h00;
        held_q           <= 1'b0;
      end
      else if (match_w)
      begin
        interval_count_q <= 8'h00;
        held_q           <= single_w;
      end
      else if (base_tick_w && !held_q)
      begin
        interval_count_q <= interval_count_q + 8'h01;
      end
    end
  end

  // ----------------------------------------------------------------
  // Configuration and flags
  // ----------------------------------------------------------------
  logic [7:0] clock_config_d;
  logic       cfg_rollover_d;
  logic       cfg_expired_d;

  // Hardware set beats a software clear in the same cycle.
  // rollover flag
  assign cfg_rollover_d = hour_wrap_w ||
    (wr_cfg_w ? (sfr_req.wdata[rtc_hour_alarm_pkg::CC_ROLLOVER] &&
                 clock_config_q[rtc_hour_alarm_pkg::CC_ROLLOVER])
              : clock_config_q[rtc_hour_alarm_pkg::CC_ROLLOVER]);
  assign cfg_expired_d = match_w ||
    (wr_cfg_w ? (sfr_req.wdata[rtc_hour_alarm_pkg::CC_EXPIRED] &&
                 clock_config_q[rtc_hour_alarm_pkg::CC_EXPIRED])
              : clock_config_q[rtc_hour_alarm_pkg::CC_EXPIRED]);

  always_comb
  begin
    clock_config_d = wr_cfg_w ? sfr_req.wdata : clock_config_q;
    clock_config_d[rtc_hour_alarm_pkg::CC_ROLLOVER] = cfg_rollover_d;
    clock_config_d[rtc_hour_alarm_pkg::CC_EXPIRED]  = cfg_expired_d;
  end

  always_ff @(posedge clock or posedge rst)
  begin
    if (rst)
    begin
      hr_counter_q           <= rtc_hour_alarm_pkg::REG_RESET;
      alarm_interval_q       <= rtc_hour_alarm_pkg::REG_RESET;
      nominal_crystal_trim_q <= rtc_hour_alarm_pkg::REG_RESET;
      thermal_crystal_trim_q <= rtc_hour_alarm_pkg::REG_RESET;
      pin_function_config_q  <= rtc_hour_alarm_pkg::REG_RESET;
      clock_config_q         <= rtc_hour_alarm_pkg::REG_RESET;
      write_unlock_key_q     <= rtc_hour_alarm_pkg::REG_RESET;
    end
    else if (clk_en)
    begin
      hr_counter_q   <= hr_counter_d;
      clock_config_q <= clock_config_d;
      if (wr_alarm_w)
        alarm_interval_q <= sfr_req.wdata;
      if (wr_nom_w)
        nominal_crystal_trim_q <= sfr_req.wdata;
      if (wr_therm_w)
        thermal_crystal_trim_q <= sfr_req.wdata;
      if (wr_pin_w)
        pin_function_config_q <= sfr_req.wdata & ~(8'h01 << rtc_hour_alarm_pkg::PF_RESERVED);
      if (wr_key_w)
        write_unlock_key_q <= sfr_req.wdata;
    end
  end

  // ----------------------------------------------------------------
  // Read data, trim sum and pin decode
  // ----------------------------------------------------------------
  logic [7:0]        rdata_w;
  logic signed [8:0] trim_sum_w;
  logic signed [8:0] trim_clip_w;
  logic [2:0]        irq1_cfg_w;
  rtc_hour_alarm_pkg::pin_func_t pin_func_w;

  assign rdata_w =
    (sfr_req.addr == rtc_hour_alarm_pkg::ADDR_HR_COUNTER) ? hr_counter_q           :
    (sfr_req.addr == rtc_hour_alarm_pkg::ADDR_ALARM_INT)  ? alarm_interval_q       :
    (sfr_req.addr == rtc_hour_alarm_pkg::ADDR_NOM_TRIM)   ? nominal_crystal_trim_q :
    (sfr_req.addr == rtc_hour_alarm_pkg::ADDR_THERM_TRIM) ? thermal_crystal_trim_q :
    (sfr_req.addr == rtc_hour_alarm_pkg::ADDR_PIN_FUNC)   ? pin_function_config_q  :
    (sfr_req.addr == rtc_hour_alarm_pkg::ADDR_CLOCK_CFG)  ? clock_config_q         :
    8'h00;

  // summed trim with clamp; trims are signed two's complement, 2 ppm a step.
  assign trim_sum_w  = 9'(signed'(nominal_crystal_trim_q)) + 9'(signed'(thermal_crystal_trim_q));
  assign trim_clip_w = (trim_sum_w >  signed'({1'b0, rtc_hour_alarm_pkg::TRIM_LIMIT})) ?
                         signed'({1'b0, rtc_hour_alarm_pkg::TRIM_LIMIT}) :
                       (trim_sum_w < -signed'({1'b0, rtc_hour_alarm_pkg::TRIM_LIMIT})) ?
                         -signed'({1'b0, rtc_hour_alarm_pkg::TRIM_LIMIT}) : trim_sum_w;

  assign irq1_cfg_w = pin_function_config_q[rtc_hour_alarm_pkg::PF_IRQ1_HI:
                                            rtc_hour_alarm_pkg::PF_IRQ1_LO];
  assign pin_func_w.irq1_gpio    = (irq1_cfg_w[1:0] == 2'h0);
  assign pin_func_w.irq1_battery = (irq1_cfg_w[1:0] == 2'h1);
  assign pin_func_w.irq1_enable  = (irq1_cfg_w[2:1] == 2'h3);
  assign pin_func_w.irq0_enable  = pin_function_config_q[rtc_hour_alarm_pkg::PF_IRQ0];

  // ----------------------------------------------------------------
  // Calibration output
  // ----------------------------------------------------------------
  logic cal_en_w;
  logic cal_wave_w;
  rtc_hour_alarm_pkg::cal_freq_t cal_freq_w;

  assign cal_en_w   = pin_function_config_q[rtc_hour_alarm_pkg::PF_CAL_EN];
  assign cal_freq_w = rtc_hour_alarm_pkg::cal_freq_t'(
    pin_function_config_q[rtc_hour_alarm_pkg::PF_FSEL_HI:rtc_hour_alarm_pkg::PF_FSEL_LO]);

  cal_clock_gen u_cal
  (
    .clock  (clock),
    .rst    (rst),
    .enable (clk_en),
    .run    (cal_en_w),
    .freq   (cal_freq_w),
    .wave   (cal_wave_w)
  );

  // Outputs are registered so the pins never see decode glitches.
  always_ff @(posedge clock or posedge rst)
  begin
    if (rst)
    begin
      sfr_rdata          <= 8'h00;
      clock_irq_pending  <= 1'b0;
      cal_pin_out        <= 1'b0;
      cal_pin_oe         <= 1'b0;
      trim_total         <= 9'sh000;
      pin_func           <= '0;
      ext_irq0_req       <= 1'b0;
      ext_irq1_req       <= 1'b0;
      battery_ctrl_input <= 1'b0;
    end
    else if (clk_en)
    begin
      sfr_rdata          <= sfr_req.rd ? rdata_w : 8'h00;
      clock_irq_pending  <= hour_wrap_w || match_w;
      cal_pin_out        <= cal_wave_w;
      cal_pin_oe         <= cal_en_w;
      trim_total         <= trim_clip_w;
      pin_func           <= pin_func_w;
      ext_irq0_req       <= pin_func_w.irq0_enable && ext_irq0_pin;
      ext_irq1_req       <= pin_func_w.irq1_enable && ext_irq1_pin;
      battery_ctrl_input <= pin_func_w.irq1_battery && ext_irq1_pin;
    end
  end

endmodule : rtc_hour_alarm

`default_nettype wire

// ### hw/rtc_hour_alarm_pkg.sv
/*
  Package for the hour counter, interval alarm, crystal trim and calibration output block.
  Assumes a single 200 MHz system clock and an 8-bit special function register port.
*/
`default_nettype none

package rtc_hour_alarm_pkg;

  // ----------------------------------------------------------------
  // Register addresses
  // ----------------------------------------------------------------
  localparam logic [7:0] ADDR_HR_COUNTER  = 8'hA5;
  localparam logic [7:0] ADDR_ALARM_INT   = 8'hA6;
  localparam logic [7:0] ADDR_NOM_TRIM    = 8'hF6;
  localparam logic [7:0] ADDR_THERM_TRIM  = 8'hF7;
  localparam logic [7:0] ADDR_PIN_FUNC    = 8'hFF;
  localparam logic [7:0] ADDR_CLOCK_CFG   = 8'hA1;
  localparam logic [7:0] ADDR_UNLOCK_KEY  = 8'hC1;

  localparam logic [7:0] REG_RESET        = 8'h00;
  localparam logic [7:0] UNLOCK_VALUE     = 8'hEA;

  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int PF_CAL_EN      = 7;
  localparam int PF_FSEL_HI     = 6;
  localparam int PF_FSEL_LO     = 5;
  localparam int PF_RESERVED    = 4;
  localparam int PF_IRQ1_HI     = 3;
  localparam int PF_IRQ1_LO     = 1;
  localparam int PF_IRQ0        = 0;
  localparam int CC_DAY_LEN     = 6;
  localparam int CC_ITS_HI      = 5;
  localparam int CC_ITS_LO      = 4;
  localparam int CC_SINGLE      = 3;
  localparam int CC_EXPIRED     = 2;
  localparam int CC_ITEN        = 1;
  localparam int CC_ROLLOVER    = 7;

  // ----------------------------------------------------------------
  // Counting constants
  // ----------------------------------------------------------------
  localparam logic [7:0] HOUR_LAST_24   = 8'h17;
  localparam logic [7:0] HOUR_LAST_256  = 8'hFF;
  localparam logic [5:0] MINUTE_LAST    = 6'h3B;
  localparam logic [7:0] TRIM_LIMIT     = 8'h7C;
  localparam int         TRIM_PPM_LSB   = 2;
  localparam int         TRIM_LIMIT_PPM = 248;

  localparam int CLOCK_HZ   = 200_000_000;
  localparam int XTAL_HZ    = 32_768;
  localparam int HZ_1       = 1;
  localparam int HZ_128     = 128;
  localparam int HZ_500     = 500;
  localparam int HZ_512     = 512;
  localparam int HZ_16384   = 16_384;

  // Half periods in system cycles for each calibration frequency.
  localparam int CAL_HALF_1     = CLOCK_HZ / (2 * HZ_1);
  localparam int CAL_HALF_512   = CLOCK_HZ / (2 * HZ_512);
  localparam int CAL_HALF_500   = CLOCK_HZ / (2 * HZ_500);
  localparam int CAL_HALF_16384 = CLOCK_HZ / (2 * HZ_16384);
  localparam int XTAL_DIV       = CLOCK_HZ / XTAL_HZ;

  typedef enum logic [1:0]
  {
    CAL_1HZ     = 2'b00,
    CAL_512HZ   = 2'b01,
    CAL_500HZ   = 2'b10,
    CAL_16384HZ = 2'b11
  } cal_freq_t;

  typedef enum logic [1:0]
  {
    BASE_128TH  = 2'b00,
    BASE_SECOND = 2'b01,
    BASE_MINUTE = 2'b10,
    BASE_HOUR   = 2'b11
  } interval_base_t;

  // Register bus request carried as one bundle.
  typedef struct packed
  {
    logic       wr;
    logic       rd;
    logic [7:0] addr;
    logic [7:0] wdata;
  } sfr_req_t;

  // Pin function decode handed to the pin logic.
  typedef struct packed
  {
    logic irq1_gpio;
    logic irq1_battery;
    logic irq1_enable;
    logic irq0_enable;
  } pin_func_t;

endpackage : rtc_hour_alarm_pkg

`default_nettype wire

// ### hw/cal_clock_gen.sv
/*
  Calibration clock generator: a toggle divider whose half period follows the selected frequency.
  Assumes the tick source is the compensated crystal reference folded into the system clock.
*/
`default_nettype none

module cal_clock_gen
(
  input  wire logic                         clock,
  input  wire logic                         rst,
  input  wire logic                         enable,
  input  wire logic                         run,
  input  wire rtc_hour_alarm_pkg::cal_freq_t freq,
  output logic                              wave
);

  // ----------------------------------------------------------------
  // Divider
  // ----------------------------------------------------------------
  logic [27:0] count_q;
  logic [27:0] half_w;
  logic        wrap_w;

  // Half period lookup, kept as constants so no table file is needed.
  assign half_w = (freq == rtc_hour_alarm_pkg::CAL_1HZ)   ? 28'(rtc_hour_alarm_pkg::CAL_HALF_1)   :
                  (freq == rtc_hour_alarm_pkg::CAL_512HZ) ? 28'(rtc_hour_alarm_pkg::CAL_HALF_512) :
                  (freq == rtc_hour_alarm_pkg::CAL_500HZ) ? 28'(rtc_hour_alarm_pkg::CAL_HALF_500) :
                  28'(rtc_hour_alarm_pkg::CAL_HALF_16384);
  assign wrap_w = (count_q >= half_w - 28'h0000001);

  // The divider is held low while run is low so the pin starts each burst on a clean edge.
  always_ff @(posedge clock or posedge rst)
  begin
    if (rst)
    begin
      count_q <= 28'h0000000;
      wave    <= 1'b0;
    end
    else if (enable)
    begin
      if (!run)
      begin
        count_q <= 28'h0000000;
        wave    <= 1'b0;
      end
      else if (wrap_w)
      begin
        count_q <= 28'h0000000;
        wave    <= ~wave;
      end
      else
      begin
        count_q <= count_q + 28'h0000001;
      end
    end
  end

endmodule : cal_clock_gen

`default_nettype wire

// ### sim/rtc_hour_alarm_checker.sv
/*
  Checker for the hour, alarm, trim and pin configuration block.
  Assumes it is bound to the top module and sees only its ports.
*/
`default_nettype none

module rtc_hour_alarm_checker
#(
  parameter int HOUR_WIDTH = 8
)
(
  input wire logic                          clock,
  input wire logic                          rst,
  input wire logic                          clk_en,
  input wire rtc_hour_alarm_pkg::sfr_req_t  sfr_req,
  input wire logic [7:0]                    sfr_rdata,
  input wire logic                          minute_wrap,
  input wire logic                          tick_128th,
  input wire logic                          tick_second,
  input wire logic                          tick_minute,
  input wire logic                          clock_irq_pending,
  input wire logic                          cal_pin_out,
  input wire logic                          cal_pin_oe,
  input wire logic signed [8:0]             trim_total,
  input wire rtc_hour_alarm_pkg::pin_func_t pin_func,
  input wire logic                          ext_irq0_req
);
  timeunit 1ns;
  timeprecision 1ps;

  // ----------------------------------------------------------------
  // Shadow registers
  // ----------------------------------------------------------------
  // The registers are hidden behind the port, so accepted key, pin and trim writes are mirrored here.
  logic [7:0] key_q;
  logic [7:0] cfg_q;
  logic [7:0] nom_q;
  logic [7:0] thr_q;
  logic [1:0] calm_q;
  wire        wr_ok   = clk_en && sfr_req.wr;
  wire        cfg_wr  = wr_ok && sfr_req.addr == 8'hFF && key_q == 8'hEA;
  wire        touch   = cfg_wr || (wr_ok && sfr_req.addr inside {8'hF6, 8'hF7});
  wire        mapped  = sfr_req.addr inside {8'hA1, 8'hA5, 8'hA6, 8'hF6, 8'hF7, 8'hFF};
  wire        ev      = minute_wrap || tick_128th || tick_second || tick_minute;
  wire        settled = calm_q == 2'h3;
  wire signed [9:0] tsum = $signed({nom_q[7], nom_q}) + $signed({thr_q[7], thr_q});
  wire signed [8:0] tclamp = (tsum > 124) ? 9'sh07C : (tsum < -124) ? -9'sh07C : tsum[8:0];
  wire rtc_hour_alarm_pkg::pin_func_t pf_exp =
    {cfg_q[2:1] == 2'b00, cfg_q[2:1] == 2'b01, cfg_q[3:2] == 2'b11, cfg_q[0]};

  // Mirror accepted key, pin and trim writes and count calm cycles since the last pin or trim write.
  always_ff @(posedge clock or posedge rst)
  begin
    if (rst)
    begin
      key_q  <= 8'h00;
      cfg_q  <= 8'h00;
      nom_q  <= 8'h00;
      thr_q  <= 8'h00;
      calm_q <= 2'h0;
    end
    else
    begin
      if (wr_ok && sfr_req.addr == 8'hC1) key_q <= sfr_req.wdata;
      if (cfg_wr) cfg_q <= sfr_req.wdata & 8'hEF;
      if (wr_ok && sfr_req.addr == 8'hF6) nom_q <= sfr_req.wdata;
      if (wr_ok && sfr_req.addr == 8'hF7) thr_q <= sfr_req.wdata;
      calm_q <= touch ? 2'h0 : (settled ? calm_q : calm_q + 2'h1);
    end
  end

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge clock);
  endclocking
  default disable iff (rst);

  sequence s_cal_on;
    cfg_wr && sfr_req.wdata[7];
  endsequence

  a_rdata_only_read: assert property
    ($past(clk_en) && sfr_rdata != 8'h00 |-> $past(sfr_req.rd && mapped))
    else $error("stray read data");
  a_irq_has_cause: assert property
    (clock_irq_pending |-> $past(ev, 1) || $past(ev, 2) || $past(ev, 3) || $past(ev, 4))
    else $error("interrupt without an event");
  a_irq_one_cycle: assert property
    (clock_irq_pending |=> !clock_irq_pending) else $error("interrupt pulse too long");
  a_cal_oe_rises: assert property
    (s_cal_on |-> ##[1:3] cal_pin_oe) else $error("calibration output not driven");
  a_cal_oe_off: assert property
    (settled && !cfg_q[7] |-> !cal_pin_oe) else $error("calibration output driven while off");
  a_pin_decode_ok: assert property
    (settled |-> pin_func == pf_exp) else $error("pin function decode wrong");
  a_irq0_gate_off: assert property
    (settled && !cfg_q[0] |-> !ext_irq0_req) else $error("disabled irq0 passed through");
  a_trim_sum_clamp: assert property
    (settled |-> trim_total == tclamp) else $error("trim sum wrong");
  a_freeze_holds: assert property
    (!clk_en |=> $stable(cal_pin_out) && $stable(trim_total)) else $error("state moved while frozen");

endmodule : rtc_hour_alarm_checker

bind rtc_hour_alarm rtc_hour_alarm_checker #(.HOUR_WIDTH(HOUR_WIDTH)) u_chk
(
  .clock(clock), .rst(rst), .clk_en(clk_en), .sfr_req(sfr_req), .sfr_rdata(sfr_rdata),
  .minute_wrap(minute_wrap), .tick_128th(tick_128th), .tick_second(tick_second),
  .tick_minute(tick_minute), .clock_irq_pending(clock_irq_pending), .cal_pin_out(cal_pin_out),
  .cal_pin_oe(cal_pin_oe), .trim_total(trim_total), .pin_func(pin_func),
  .ext_irq0_req(ext_irq0_req)
);

`default_nettype wire

// ### sim/tb_rtc_hour_alarm.sv
/*
  Self-checking bench for the hour, alarm, trim and pin configuration block.
  Assumes the design package is compiled first; inputs change on falling edges.
*/
`default_nettype none

module tb_rtc_hour_alarm;
  timeunit 1ns;
  timeprecision 1ps;

  logic clock, rst, clk_en, minute_wrap, tick_128th, tick_second, tick_minute;
  logic ext_irq0_pin, ext_irq1_pin, irq, cal_out, cal_oe, q0, q1, bat;
  rtc_hour_alarm_pkg::sfr_req_t  req;
  rtc_hour_alarm_pkg::pin_func_t pf;
  logic [7:0] rdata, d, v, w;
  logic [3:0] e;
  logic signed [8:0] trim;
  int failures, comparisons, irqs, n, m;

  rtc_hour_alarm u_dut
  (
    .clock(clock), .rst(rst), .clk_en(clk_en), .sfr_req(req), .sfr_rdata(rdata),
    .minute_wrap(minute_wrap), .tick_128th(tick_128th), .tick_second(tick_second),
    .tick_minute(tick_minute), .ext_irq0_pin(ext_irq0_pin), .ext_irq1_pin(ext_irq1_pin),
    .clock_irq_pending(irq), .cal_pin_out(cal_out), .cal_pin_oe(cal_oe), .trim_total(trim),
    .pin_func(pf), .ext_irq0_req(q0), .ext_irq1_req(q1), .battery_ctrl_input(bat)
  );

  initial
  begin
    clock = 1'b0;
    forever #2.5 clock = ~clock;
  end

  // Count interrupt pulses; a pulse lasts one cycle so each edge counts once.
  always @(posedge clock) if (irq === 1'b1) irqs++;

  // ----------------------------------------------------------------
  // Tasks and expectation functions
  // ----------------------------------------------------------------
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    comparisons++;
    if (seen !== exp)
    begin
      failures++;
      $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check

  task automatic wr(input logic [7:0] a, input logic [7:0] x);
    @(negedge clock);
    req = '{1'b1, 1'b0, a, x};
    @(negedge clock);
    req = '0;
  endtask : wr

  // Read data is registered, so it is taken in the cycle after the strobe.
  task automatic rd(input logic [7:0] a, output logic [7:0] x);
    @(negedge clock);
    req = '{1'b0, 1'b1, a, 8'h00};
    @(negedge clock);
    req = '0;
    x = rdata;
  endtask : rd

  // Pulses are spaced five cycles apart so every interrupt is seen alone.
  task automatic pulse(input int k, input int reps);
    repeat (reps)
    begin
      @(negedge clock);
      case (k)
        0: tick_128th = 1'b1;
        1: tick_second = 1'b1;
        2: tick_minute = 1'b1;
        default: minute_wrap = 1'b1;
      endcase
      @(negedge clock);
      {tick_128th, tick_second, tick_minute, minute_wrap} = 4'h0;
      repeat (3) @(negedge clock);
    end
  endtask : pulse

  function automatic logic [8:0] exp_trim(input logic [7:0] a, input logic [7:0] b);
    logic signed [9:0] s;
    s = $signed({a[7], a}) + $signed({b[7], b});
    return (s > 124) ? 9'h07C : (s < -124) ? 9'h184 : s[8:0];
  endfunction : exp_trim

  function automatic logic [3:0] exp_pf(input logic [7:0] c);
    return {c[2:1] == 2'b00, c[2:1] == 2'b01, c[3:2] == 2'b11, c[0]};
  endfunction : exp_pf

  task automatic wrap_up();
    $display("comparisons=%0d failures=%0d", comparisons, failures);
    if (failures == 0 && comparisons > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask : wrap_up

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial
  begin
    n = $urandom(32'h7EE52896);
    {rst, clk_en, req, minute_wrap, tick_128th, tick_second, tick_minute} = '0;
    {ext_irq0_pin, ext_irq1_pin} = 2'b00;
    rst = 1'b1;
    repeat (20) @(negedge clock);
    rst = 1'b0;
    clk_en = 1'b1;
    for (int i = 0; i < 8; i++)
    begin
      rd(8'hA0 + 8'(i * 13), d);
      check(d, 8'h00);
    end
    rd(8'hA5, d); check(d, 8'h00);
    // Writes to locked registers are dropped until the key is written.
    wr(8'hA5, 8'h3C); rd(8'hA5, d); check(d, 8'h00);
    wr(8'hC1, 8'hEA); wr(8'hA1, 8'h40); wr(8'hA5, 8'h16);
    pulse(3, 1); rd(8'hA5, d); check(d, 8'h17);
    check(irqs, 0);
    pulse(3, 1); rd(8'hA5, d); check(d, 8'h00);
    check(irqs, 1);
    wr(8'hA1, 8'h00); wr(8'hA5, 8'hFE); pulse(3, 2); rd(8'hA5, d); check(d, 8'h00);
    check(irqs, 2);
    rd(8'hA1, d); check(d[7], 1'b1);
    pulse(2, 3); rd(8'hA5, d); check(d, 8'h00);
    // Every time base, one of them at the widest interval.
    for (int b = 0; b < 4; b++)
    begin
      n = (b == 1) ? 255 : $urandom_range(7, 1);
      // The first base runs single shot, so a second interval must stay silent.
      wr(8'hA1, 8'h00); wr(8'hA6, n[7:0]); wr(8'hA1, {2'b00, b[1:0], b == 0, 3'b010});
      m = irqs;
      pulse(b, n - 1); check(irqs - m, 0);
      pulse(b, 1); check(irqs - m, 1);
      rd(8'hA1, d); check(d[2], 1'b1);
      pulse(b, n); check(irqs - m, (b == 0) ? 1 : 2);
    end
    wr(8'hA1, 8'h00); rd(8'hA1, d); check(d[2], 1'b0);
    wr(8'hA1, 8'h04); rd(8'hA1, d); check(d[2], 1'b0);
    for (int i = 0; i < 8; i++)
    begin
      v = (i == 0) ? 8'h7F : (i == 1) ? 8'h80 : 8'($urandom);
      w = (i == 0) ? 8'h7F : (i == 1) ? 8'h80 : 8'($urandom);
      wr(8'hF6, v); wr(8'hF7, w); repeat (3) @(negedge clock);
      check($unsigned(trim), exp_trim(v, w));
      rd(8'hF6, d); check(d, v);
      rd(8'hF7, d); check(d, w);
    end
    {ext_irq0_pin, ext_irq1_pin} = 2'b11;
    for (int c = 0; c < 16; c++)
    begin
      v = {3'b000, 1'b1, c[3:0]};
      e = exp_pf(v);
      wr(8'hFF, v); repeat (3) @(negedge clock);
      check(pf, e);
      check(bat, e[2]);
      check(q1, e[1]);
      check(q0, v[0]);
      rd(8'hFF, d); check(d, v & 8'hEF);
    end
    for (int f = 0; f < 4; f++)
    begin
      wr(8'hFF, {1'b1, f[1:0], 5'b0}); repeat (3) @(negedge clock); check(cal_oe, 1'b1);
    end
    // Only the fastest setting fits the run; slower ones are covered by enable alone.
    repeat (2)
    begin
      n = 0;
      v[0] = cal_out;
      while (cal_out === v[0] && n < 20000) begin @(negedge clock); n++; end
    end
    check(n >= rtc_hour_alarm_pkg::CAL_HALF_16384 - 2 && n <= rtc_hour_alarm_pkg::CAL_HALF_16384 + 2, 1'b1);
    rd(8'hA5, w); clk_en = 1'b0; pulse(3, 1); clk_en = 1'b1;
    rd(8'hA5, d); check(d, w);
    wr(8'hFF, 8'h00); repeat (3) @(negedge clock); check(cal_oe, 1'b0);
    wr(8'hC1, 8'hEA); wr(8'hA5, 8'h09); rst = 1'b1; @(negedge clock); rst = 1'b0;
    rd(8'hA5, d); check(d, 8'h00);
    rd(8'hF6, d); check(d, 8'h00);
    wrap_up();
  end

  // Cut a hang short well inside the cycle budget.
  initial
  begin
    #400000;
    failures++;
    wrap_up();
  end

endmodule : tb_rtc_hour_alarm

`default_nettype wire
